// ==== hw/scsp_pkg.sv ====
// constants for the system clock source and prescaler block
`default_nettype none
package scsp_pkg;
    localparam logic [11:0] ADDR_TRIM     = 12'h000;
    localparam logic [11:0] ADDR_DIVCTL   = 12'h004;
    localparam logic [11:0] ADDR_SETTINGS = 12'h008;
    localparam logic [11:0] ADDR_TIMER    = 12'h00C;
    localparam logic [11:0] ADDR_STATUS   = 12'h010;
    // settings fields
    localparam int SET_CLOCK_SOURCE_SELECT_SETTING_LSB = 0;
    localparam int SET_SUT_LSB   = 4;
    localparam int SET_RSTDIS    = 6;
    localparam int SET_CLKOUT    = 7;
    localparam int SET_DIV8      = 8;
    localparam logic [8:0] SETTINGS_RESET = 9'h103;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_SETTING_EXT   = 4'h0;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_SETTING_RC    = 4'h2;
    localparam logic [3:0] CLOCK_SOURCE_SELECT_SETTING_128K  = 4'h3;
    localparam logic [1:0] SUT_BOD     = 2'h0;
    localparam logic [1:0] SUT_FAST    = 2'h1;
    localparam logic [1:0] SUT_SLOW    = 2'h2;
    // divider control fields
    localparam int DIV_CE_BIT = 7;
    localparam logic [7:0] DIV_UNLOCK = 8'h80;
    localparam logic [3:0] DIV_MAX_CODE = 4'h8;
    localparam logic [3:0] DIVSEL_RESET =
        SETTINGS_RESET[SET_DIV8] ? 4'h3 : 4'h0;
    localparam logic [2:0] CE_WINDOW = 3'h4;
    // timer control fields
    localparam int TMR_ENABLE = 0;
    localparam int TMR_TIMER_EXTERNAL_CLOCK_SELECT = 1;
    // timing
    localparam int CLK_MHZ   = 25;
    localparam logic [3:0] RESET_CK = 4'hE;
    localparam logic [3:0] WAKE_CK  = 4'h6;
    localparam int T_4MS_US   = 4000;
    localparam int T_4P1MS_US = 4100;
    localparam int T_64MS_US  = 64000;
    localparam int T_65MS_US  = 65000;
    localparam int CYC_4MS   = T_4MS_US * CLK_MHZ;
    localparam int CYC_4P1MS = T_4P1MS_US * CLK_MHZ;
    localparam int CYC_64MS  = T_64MS_US * CLK_MHZ;
    localparam int CYC_65MS  = T_65MS_US * CLK_MHZ;
    typedef enum logic [1:0] {
        ST_CK   = 2'b00,
        ST_MS   = 2'b01,
        ST_RUN  = 2'b10,
        ST_WAKE = 2'b11
    } scsp_state_type;
endpackage : scsp_pkg
`default_nettype wire

// ==== hw/scsp_clock_ctrl.sv ====
// clock source select, start-up delay, prescaler and trim with ahb-lite registers
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`default_nettype none
module scsp_clock_ctrl #(
    parameter logic [7:0]  FACTORY_TRIM = 8'h80,
    parameter int unsigned MS4_CYC   = scsp_pkg::CYC_4MS,
    parameter int unsigned MS4P1_CYC = scsp_pkg::CYC_4P1MS,
    parameter int unsigned MS64_CYC  = scsp_pkg::CYC_64MS,
    parameter int unsigned MS65_CYC  = scsp_pkg::CYC_65MS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        crystal_input_pin,
    input  wire logic        osc_128k_clk,
    input  wire logic        rc_osc_clk,
    input  wire logic        wake_request,
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe,
    output logic             sys_clk,
    output logic             core_hold,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    output logic             timer_osc_enable,
    output logic             timer_external_clock_select,
    output logic             trim_range_bit,
    output logic [6:0]       trim_fine_bits
);
    logic [7:0]  trim_reg;
    logic [3:0]  sel_reg;
    logic        ce_reg;
    logic [2:0]  ce_cnt_reg;
    logic [8:0]  settings_reg;
    logic [1:0]  timer_reg;
    logic        wr_pend_reg;
    logic [11:0] waddr_reg;
    logic        req_reg;
    logic [6:0]  src_sync_reg;
    logic [3:0]  eff_reg;
    logic [3:0]  pend_code_reg;
    logic        pend_reg;
    logic [7:0]  cnt_reg;
    logic        sysclk_reg;
    logic [3:0]  cnt_next;
    logic [7:0]  pcnt_next;
    logic [3:0]  eff_next;
    logic        sysclk_next;
    logic        boundary;
    logic [8:0]  mask9;
    logic        src_rise;
    logic        src_sel;
    logic [3:0]  clock_source_select_setting;
    logic [1:0]  startup_time_setting;
    logic [7:0]  wdata8;
    logic        wr_trim;
    logic        wr_div;
    logic        wr_set;
    logic        wr_tmr;
    logic        addr_ok;
    logic        rc_source;
    scsp_pkg::scsp_state_type state_reg;
    logic [3:0]  tick_cnt_reg;
    logic [20:0] ms_cnt_reg;
    logic [20:0] ms_load;
    logic        hold_reg;
    logic        pin_reg;
    logic        pin_oe_reg;
    logic        tosc_en_reg;
    logic        tosc_ext_reg;

    assign clock_source_select_setting  = settings_reg[scsp_pkg::SET_CLOCK_SOURCE_SELECT_SETTING_LSB +: 4];
    assign startup_time_setting    = settings_reg[scsp_pkg::SET_SUT_LSB +: 2];
    assign wdata8 = hwdata[7:0];
    assign rc_source = (clock_source_select_setting == scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_RC) || (clock_source_select_setting == scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_128K);
    assign addr_ok = hsel && hready && htrans[1];

    // ---------------- ahb-lite slave, zero wait states ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 12'h000;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b0;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= addr_ok && hwrite;
            waddr_reg   <= haddr[11:0];
            if (addr_ok && !hwrite) begin
                unique case (haddr[11:0])
                    scsp_pkg::ADDR_TRIM:     hrdata <= {24'h000000, trim_reg};
                    scsp_pkg::ADDR_DIVCTL:   hrdata <= {24'h000000, ce_reg, 3'h0, sel_reg};
                    scsp_pkg::ADDR_SETTINGS: hrdata <= {23'h000000, settings_reg};
                    scsp_pkg::ADDR_TIMER:    hrdata <= {30'h00000000, timer_reg};
                    scsp_pkg::ADDR_STATUS:   hrdata <= {24'h000000, pend_reg, tosc_en_reg,
                                                        state_reg, eff_reg};
                    default:                 hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wr_trim = wr_pend_reg && (waddr_reg == scsp_pkg::ADDR_TRIM);
    assign wr_div  = wr_pend_reg && (waddr_reg == scsp_pkg::ADDR_DIVCTL);
    assign wr_set  = wr_pend_reg && (waddr_reg == scsp_pkg::ADDR_SETTINGS);
    assign wr_tmr  = wr_pend_reg && (waddr_reg == scsp_pkg::ADDR_TIMER);

    // trim: factory value at reset, software may retune
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_reg <= FACTORY_TRIM;
        end else if (wr_trim) begin
            trim_reg <= wdata8;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settings_reg <= scsp_pkg::SETTINGS_RESET;
            timer_reg    <= 2'h0;
        end else begin
            if (wr_set) begin
                settings_reg <= hwdata[8:0];
            end
            if (wr_tmr) begin
                timer_reg <= hwdata[1:0];
            end
        end
    end

    // timed unlock of the divider select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
            sel_reg    <= scsp_pkg::DIVSEL_RESET;
            req_reg    <= 1'b0;
        end else begin
            req_reg <= 1'b0;
            if (wr_div && !ce_reg && wdata8 == scsp_pkg::DIV_UNLOCK) begin
                ce_reg     <= 1'b1;
                ce_cnt_reg <= scsp_pkg::CE_WINDOW;
            end else if (wr_div && ce_reg && !wdata8[scsp_pkg::DIV_CE_BIT]) begin
                sel_reg <= wdata8[3:0];
                ce_reg  <= 1'b0;
                req_reg <= (wdata8[3:0] <= scsp_pkg::DIV_MAX_CODE);
            end else if (ce_reg) begin
                // a repeated unlock falls here and leaves the window running
                ce_cnt_reg <= ce_cnt_reg - 3'h1;
                ce_reg     <= (ce_cnt_reg != 3'h1);
            end
        end
    end

    // ---------------- source select and synchroniser ----------------
    always_comb begin
        unique case (clock_source_select_setting)
            scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_128K: src_sel = src_sync_reg[4];
            scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_EXT:  src_sel = src_sync_reg[5];
            default:              src_sel = src_sync_reg[3];
        endcase
    end

    // oscillators are asynchronous: [2:0] feeds only [5:3], the mux reads [5:3]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_sync_reg <= 7'h00;
        end else begin
            src_sync_reg <= {src_sel, src_sync_reg[2:0], crystal_input_pin, osc_128k_clk,
                             rc_osc_clk};
        end
    end

    assign src_rise = src_sel && !src_sync_reg[6];

    // ---------------- prescaler ----------------
    // period of the divided clock starts where the low code bits wrap
    always_comb begin
        mask9       = (9'h001 << eff_reg) - 9'h001;
        pcnt_next   = cnt_reg + 8'h01;
        boundary    = (pcnt_next & mask9[7:0]) == 8'h00;
        eff_next    = eff_reg;
        cnt_next    = 4'h0;
        if (src_rise && boundary && pend_reg) begin
            eff_next  = pend_code_reg;
            pcnt_next = 8'h00;
        end else if (!src_rise) begin
            pcnt_next = cnt_reg;
        end
        if (eff_next == 4'h0) begin
            sysclk_next = src_sel;
        end else begin
            cnt_next    = eff_next - 4'h1;
            sysclk_next = !pcnt_next[cnt_next[2:0]];
        end
    end

    // switching only at a period start keeps every pulse full length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eff_reg       <= scsp_pkg::DIVSEL_RESET;
            pend_reg      <= 1'b0;
            pend_code_reg <= 4'h0;
            cnt_reg       <= 8'h00;
            sysclk_reg    <= 1'b0;
        end else begin
            eff_reg    <= eff_next;
            cnt_reg    <= pcnt_next;
            sysclk_reg <= sysclk_next;
            if (req_reg) begin
                pend_reg      <= 1'b1;
                pend_code_reg <= sel_reg;
            end else if (src_rise && boundary) begin
                pend_reg <= 1'b0;
            end
        end
    end

    assign sys_clk = sysclk_reg;

    // ---------------- start-up delays ----------------
    always_comb begin
        ms_load = 21'h000000;
        unique case (startup_time_setting)
            scsp_pkg::SUT_BOD: begin
                if (rc_source && settings_reg[scsp_pkg::SET_RSTDIS]) begin
                    ms_load = MS4P1_CYC[20:0];
                end
            end
            scsp_pkg::SUT_FAST: begin
                ms_load = (clock_source_select_setting == scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_128K) ? MS4_CYC[20:0]
                                                          : MS4P1_CYC[20:0];
            end
            scsp_pkg::SUT_SLOW: begin
                ms_load = (clock_source_select_setting == scsp_pkg::CLOCK_SOURCE_SELECT_SETTING_128K) ? MS64_CYC[20:0]
                                                          : MS65_CYC[20:0];
            end
            default: ms_load = 21'h000000;
        endcase
    end

    // a stopped source stalls the first phase; there is no time-out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= scsp_pkg::ST_CK;
            tick_cnt_reg <= scsp_pkg::RESET_CK;
            ms_cnt_reg   <= 21'h000000;
            hold_reg     <= 1'b1;
        end else begin
            unique case (state_reg)
                scsp_pkg::ST_CK: begin
                    if (src_rise) begin
                        tick_cnt_reg <= tick_cnt_reg - 4'h1;
                        if (tick_cnt_reg == 4'h1) begin
                            state_reg  <= scsp_pkg::ST_MS;
                            ms_cnt_reg <= ms_load;
                        end
                    end
                end
                scsp_pkg::ST_MS: begin
                    if (ms_cnt_reg == 21'h000000) begin
                        state_reg <= scsp_pkg::ST_RUN;
                        hold_reg  <= 1'b0;
                    end else begin
                        ms_cnt_reg <= ms_cnt_reg - 21'h000001;
                    end
                end
                scsp_pkg::ST_RUN: begin
                    if (wake_request) begin
                        state_reg    <= scsp_pkg::ST_WAKE;
                        tick_cnt_reg <= scsp_pkg::WAKE_CK;
                        hold_reg     <= 1'b1;
                    end
                end
                scsp_pkg::ST_WAKE: begin
                    if (src_rise) begin
                        tick_cnt_reg <= tick_cnt_reg - 4'h1;
                        if (tick_cnt_reg == 4'h1) begin
                            state_reg <= scsp_pkg::ST_RUN;
                            hold_reg  <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    assign core_hold = hold_reg;

    // ---------------- pins ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_reg      <= 1'b0;
            pin_oe_reg   <= 1'b0;
            tosc_en_reg  <= 1'b0;
            tosc_ext_reg <= 1'b0;
        end else begin
            if (settings_reg[scsp_pkg::SET_CLKOUT]) begin
                pin_reg    <= sysclk_next;
                pin_oe_reg <= 1'b1;
            end else begin
                pin_reg    <= gpio_out;
                pin_oe_reg <= gpio_oe;
            end
            tosc_en_reg  <= timer_reg[scsp_pkg::TMR_ENABLE] && rc_source;
            tosc_ext_reg <= timer_reg[scsp_pkg::TMR_ENABLE] && rc_source
                            && timer_reg[scsp_pkg::TMR_TIMER_EXTERNAL_CLOCK_SELECT];
        end
    end

    assign clock_out_pin_o             = pin_reg;
    assign clock_out_pin_oe            = pin_oe_reg;
    assign timer_osc_enable            = tosc_en_reg;
    assign timer_external_clock_select = tosc_ext_reg;
    assign trim_range_bit              = trim_reg[7];
    assign trim_fine_bits              = trim_reg[6:0];

    // ---------------- assertions ----------------
    property p_ce_clean;
        @(posedge hclk) disable iff (!hresetn)
        (wr_div && !ce_reg && wdata8 != scsp_pkg::DIV_UNLOCK) |=> !ce_reg;
    endproperty
    a_ce_clean: assert property (p_ce_clean) else $error("change enable set by unclean write");

    property p_ce_timeout;
        @(posedge hclk) disable iff (!hresetn)
        $rose(ce_reg) |-> ##4 !ce_reg;
    endproperty
    a_ce_timeout: assert property (p_ce_timeout) else $error("change enable outlived window");

    property p_ce_hold;
        @(posedge hclk) disable iff (!hresetn)
        ($rose(ce_reg) && !wr_div) ##1 !wr_div |-> ce_reg;
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("change enable cleared early");

    property p_ce_rewrite;
        @(posedge hclk) disable iff (!hresetn)
        (ce_reg && wr_div && wdata8 == scsp_pkg::DIV_UNLOCK && ce_cnt_reg > 3'h1)
            |=> ce_reg && ce_cnt_reg == $past(ce_cnt_reg) - 3'h1;
    endproperty
    a_ce_rewrite: assert property (p_ce_rewrite) else $error("rewrite changed window");

    property p_reserved;
        @(posedge hclk) disable iff (!hresetn)
        (wr_div && ce_reg && !wdata8[scsp_pkg::DIV_CE_BIT] && wdata8[3:0] > scsp_pkg::DIV_MAX_CODE)
            |=> sel_reg == $past(wdata8[3:0]) && !req_reg;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not kept");

    property p_switch_edge;
        @(posedge hclk) disable iff (!hresetn)
        $changed(eff_reg) |-> $past(src_rise) && cnt_reg == 8'h00;
    endproperty
    a_switch_edge: assert property (p_switch_edge) else $error("factor changed mid period");

    property p_clkout;
        @(posedge hclk) disable iff (!hresetn)
        $past(settings_reg[scsp_pkg::SET_CLKOUT]) |-> clock_out_pin_oe && clock_out_pin_o == sys_clk;
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock pin not driven");

    property p_tosc;
        @(posedge hclk) disable iff (!hresetn)
        timer_osc_enable |-> $past(rc_source) && (!timer_external_clock_select
            || $past(timer_reg[scsp_pkg::TMR_TIMER_EXTERNAL_CLOCK_SELECT]));
    endproperty
    a_tosc: assert property (p_tosc) else $error("timer oscillator outside rc source");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == scsp_pkg::ST_RUN && wake_request)
            |=> state_reg == scsp_pkg::ST_WAKE && tick_cnt_reg == scsp_pkg::WAKE_CK && core_hold;
    endproperty
    a_wake: assert property (p_wake) else $error("wake delay not started");

    property p_trim;
        @(posedge hclk) disable iff (!hresetn)
        wr_trim |=> trim_range_bit == $past(wdata8[7]) && trim_fine_bits == $past(wdata8[6:0]);
    endproperty
    a_trim: assert property (p_trim) else $error("trim write lost");

    c_unlock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ce_reg));
    c_apply: cover property (@(posedge hclk) disable iff (!hresetn) $changed(eff_reg));
    c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == scsp_pkg::ST_WAKE ##1 state_reg == scsp_pkg::ST_RUN);
    c_run: cover property (@(posedge hclk) disable iff (!hresetn) $fell(core_hold));
endmodule : scsp_clock_ctrl
`default_nettype wire

// ==== tb/scsp_src_model.sv ====
// free-running clock sources seen at the block's oscillator inputs
`default_nettype none
module scsp_src_model #(
    parameter time HALF_EXT  = 100ns,
    parameter time HALF_128K = 120ns,
    parameter time HALF_RC   = 140ns
) (
    output var logic crystal_input_pin,
    output var logic osc_128k_clk,
    output var logic rc_osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // fixed periods, at least five hclk periods long so sampling can follow them
    initial begin
        crystal_input_pin = 1'b0;
        forever #(HALF_EXT) crystal_input_pin = ~crystal_input_pin;
    end
    initial begin
        osc_128k_clk = 1'b0;
        forever #(HALF_128K) osc_128k_clk = ~osc_128k_clk;
    end
    initial begin
        rc_osc_clk = 1'b0;
        forever #(HALF_RC) rc_osc_clk = ~rc_osc_clk;
    end
endmodule : scsp_src_model
`default_nettype wire

// ==== tb/tb.sv ====
// register, divider, start-up and pin checks for the clock control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, gpio_out, gpio_oe, wake_request;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic hreadyout, hresp, sys_clk, core_hold, ck_o, ck_oe, tmr_en, tmr_ext, rng;
    logic xtal, osc128, rcosc;
    logic [6:0]  fine;
    int errors = 0;
    int cmp_count = 0;
    // period of the 128 kHz model in hclk cycles
    localparam int SRC_CYC = 6;

    scsp_src_model src (.crystal_input_pin(xtal), .osc_128k_clk(osc128), .rc_osc_clk(rcosc));
    scsp_clock_ctrl #(.MS4_CYC(20), .MS4P1_CYC(25), .MS64_CYC(40), .MS65_CYC(45)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crystal_input_pin(xtal),
        .osc_128k_clk(osc128), .rc_osc_clk(rcosc), .wake_request(wake_request),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .sys_clk(sys_clk), .core_hold(core_hold),
        .clock_out_pin_o(ck_o), .clock_out_pin_oe(ck_oe), .timer_osc_enable(tmr_en),
        .timer_external_clock_select(tmr_ext), .trim_range_bit(rng), .trim_fine_bits(fine));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one single word transfer; address phase held until hready, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd_check

    // bounded poll of the applied division code
    task automatic wait_code(input logic [3:0] code);
        int i;
        for (i = 0; i < 40; i++) begin
            bus(1'b0, scsp_pkg::ADDR_STATUS, 32'h0);
            if (q[3:0] === code) break;
        end
        check({28'h0, q[3:0]}, {28'h0, code});
    endtask : wait_code

    // high and low phase of the divided clock in hclk cycles, every wait bounded
    task automatic period_check(input logic [31:0] half);
        int i;
        int n;
        for (i = 0; i < 4000 && sys_clk !== 1'b0; i++) @(posedge hclk);
        for (i = 0; i < 4000 && sys_clk !== 1'b1; i++) @(posedge hclk);
        for (n = 0; n < 4000 && sys_clk !== 1'b0; n++) @(posedge hclk);
        for (i = 0; i < 4000 && sys_clk !== 1'b1; i++) @(posedge hclk);
        check(n, half);
        check(i, half);
    endtask : period_check

    task automatic t_startup;
        int i;
        check({31'h0, core_hold}, 32'h1);
        for (i = 0; i < 400 && core_hold !== 1'b0; i++) @(posedge hclk);
        check({31'h0, core_hold}, 32'h0);
        rd_check(scsp_pkg::ADDR_TRIM, 32'h80);
        rd_check(scsp_pkg::ADDR_DIVCTL, {28'h0, scsp_pkg::DIVSEL_RESET});
        rd_check(scsp_pkg::ADDR_SETTINGS, 32'h103);
        rd_check(12'h020, 32'h0);
    endtask : t_startup

    task automatic t_trim;
        bus(1'b1, scsp_pkg::ADDR_TRIM, 32'h7F);
        rd_check(scsp_pkg::ADDR_TRIM, 32'h7F);
        check({24'h0, rng, fine}, 32'h7F);
        bus(1'b1, scsp_pkg::ADDR_TRIM, 32'h80);
        @(posedge hclk);
        check({24'h0, rng, fine}, 32'h80);
    endtask : t_trim

    task automatic t_divider;
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h01);
        rd_check(scsp_pkg::ADDR_DIVCTL, 32'h01);
        wait_code(4'h1);
        period_check(SRC_CYC);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h81);
        rd_check(scsp_pkg::ADDR_DIVCTL, 32'h01);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        repeat (6) @(posedge hclk);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h02);
        rd_check(scsp_pkg::ADDR_DIVCTL, 32'h01);
        // second unlock must not stretch the window past the first one
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        @(posedge hclk);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h04);
        rd_check(scsp_pkg::ADDR_DIVCTL, 32'h01);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h09);
        rd_check(scsp_pkg::ADDR_DIVCTL, 32'h09);
        repeat (30) @(posedge hclk);
        wait_code(4'h1);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h80);
        bus(1'b1, scsp_pkg::ADDR_DIVCTL, 32'h08);
        wait_code(4'h8);
        period_check(128 * SRC_CYC);
    endtask : t_divider

    task automatic t_pins;
        gpio_out <= 1'b1;
        gpio_oe <= 1'b1;
        repeat (3) @(posedge hclk);
        check({30'h0, ck_o, ck_oe}, 32'h3);
        gpio_oe <= 1'b0;
        bus(1'b1, scsp_pkg::ADDR_SETTINGS, 32'h183);
        repeat (3) @(posedge hclk);
        check({31'h0, ck_oe}, 32'h1);
        bus(1'b1, scsp_pkg::ADDR_TIMER, 32'h1);
        repeat (2) @(posedge hclk);
        check({30'h0, tmr_en, tmr_ext}, 32'h2);
        bus(1'b1, scsp_pkg::ADDR_TIMER, 32'h3);
        repeat (2) @(posedge hclk);
        check({30'h0, tmr_en, tmr_ext}, 32'h3);
        bus(1'b1, scsp_pkg::ADDR_SETTINGS, 32'h100);
        repeat (2) @(posedge hclk);
        check({30'h0, tmr_en, tmr_ext}, 32'h0);
        bus(1'b1, scsp_pkg::ADDR_SETTINGS, 32'h103);
    endtask : t_pins

    task automatic t_wake;
        int i;
        wake_request <= 1'b1;
        @(posedge hclk);
        wake_request <= 1'b0;
        for (i = 0; i < 10 && core_hold !== 1'b1; i++) @(posedge hclk);
        check({31'h0, core_hold}, 32'h1);
        for (i = 0; i < 200 && core_hold !== 1'b0; i++) @(posedge hclk);
        check({31'h0, core_hold}, 32'h0);
    endtask : t_wake

    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #800000;
        errors++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, wake_request, gpio_out, gpio_oe} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_startup();
        t_trim();
        t_divider();
        t_pins();
        t_wake();
        final_report();
    end
endmodule : tb
`default_nettype wire
